/* File: dv/psei_host_model.sv */
// Purpose: Host processor model that issues byte accesses on the three control ports.
// Assumes: Accesses are driven 1 ns after the rising clock edge.
// Notes: Read data is handed on with a one-cycle valid pulse.
`timescale 1ns/1ps
`default_nettype none
module psei_host_model (
    // Clock and read data.
    input wire logic clk_sys_in,
    input wire logic [psei_pkg::NUM_PORTS-1:0][7:0] rdata_in,
    // Port accesses and read results.
    output var psei_pkg::psei_access_t [psei_pkg::NUM_PORTS-1:0] access_out,
    output var logic rd_valid_out,
    output var logic [7:0] rd_data_out
);
    import psei_pkg::*;
    // One access held through its taking edge; the idle gap keeps strobes apart.
    task automatic xfer(input int p, input logic wr, input logic [7:0] a,
                        input logic [7:0] d, input logic dn);
        @(posedge clk_sys_in);
        #1 access_out[p] = '{1'b1, wr, a, d, dn};
        @(posedge clk_sys_in);
        #1 access_out[p] = '0;
        rd_data_out = rdata_in[p];
        rd_valid_out = !wr;
        @(posedge clk_sys_in);
        #1 rd_valid_out = 1'b0;
    endtask
    // Clearing writes back exactly what was read, so later events survive.
    task automatic write_back(input int p, input logic [7:0] a);
        xfer(p, 1'b0, a, 8'h00, 1'b0);
        xfer(p, 1'b1, a, rd_data_out, 1'b0);
    endtask
    // Idle bus at time zero.
    initial begin
        access_out = '0;
        rd_valid_out = 1'b0;
        rd_data_out = 8'h00;
    end
endmodule // psei_host_model
`default_nettype wire

/* File: dv/test_pmic_status_event_irq.sv */
// Purpose: Self-checking bench for the status, log and event block.
// Assumes: A short start-up window parameter stands in for 16 seconds.
// Notes: Reads queue their expectation; a monitor compares on each result.
`timescale 1ns/1ps
`default_nettype none
module test_pmic_status_event_irq;
    import psei_pkg::*;
    localparam int WIN = 20;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    psei_access_t [NUM_PORTS-1:0] acc;
    logic [NUM_PORTS-1:0][7:0] rdata;
    logic [NUM_PORTS-1:0] wmode;
    logic [NUM_PORTS-1:0][2:0] page;
    psei_live_t live = '0;
    psei_cause_t cause = '0;
    logic active = 1'b0;
    logic pwrup = 1'b1;
    logic [4:1] ev_src = '0;
    logic [2:0] other = '0;
    logic other_irq = 1'b0;
    logic [4:0] mask = '0;
    logic irq_n;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [7:0] exp_q[$];
    logic [7:0] e;
    logic [31:0] seed = 32'h8919;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;

    psei_status_event #(.START_WINDOW_CYCLES(WIN)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .host_access_in(acc), .rdata_out(rdata),
        .write_mode_out(wmode), .page_out(page), .live_in(live), .cause_in(cause),
        .active_mode_in(active), .powerup_seq_in(pwrup), .sequencer_done_event_in(ev_src[4]),
        .adc_ready_event_in(ev_src[3]), .rtc_tick_event_in(ev_src[2]),
        .rtc_alarm_event_in(ev_src[1]), .other_events_set_in(other),
        .other_irq_pending_in(other_irq), .event_mask_in(mask),
        .interrupt_request_n_out(irq_n));
    psei_host_model host_u (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .access_out(acc),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data));

    // Free-running 40 MHz clock.
    always #12.5 clk_sys_in = ~clk_sys_in;

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input int p, input logic [7:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        host_u.xfer(p, 1'b0, a, 8'h00, 1'b0);
    endtask
    task automatic wr(input int p, input logic [7:0] a, input logic [7:0] d, input logic dn);
        host_u.xfer(p, 1'b1, a, d, dn);
    endtask
    task automatic clr(input int p, input logic [7:0] a, input logic [7:0] ex);
        exp_q.push_back(ex);
        host_u.write_back(p, a);
    endtask
    // Source 0 is a power button edge, the others are one-cycle pulses.
    task automatic pulse_evt(input int i);
        @(posedge clk_sys_in);
        #1 if (i == 0) live.power_button_n = ~live.power_button_n; else ev_src[i] = 1'b1;
        @(posedge clk_sys_in);
        #1 ev_src = '0;
    endtask
    task automatic pulse_cause(input psei_cause_t c);
        @(posedge clk_sys_in);
        #1 cause = c;
        @(posedge clk_sys_in);
        #1 cause = '0;
    endtask
    task automatic irq_is(input logic lvl);
        repeat (2) @(posedge clk_sys_in);
        #1 check({7'h00, irq_n}, {7'h00, lvl});
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Every read result is matched against the oldest expectation.
    always @(posedge clk_sys_in) begin
        if (rd_valid) begin
            check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
        end
    end
    // A hang ends the run as a mismatch.
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        live.power_button_n = 1'b1;
        repeat (16) @(posedge clk_sys_in);
        #1 rst_in = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) rd(p, 8'h00, BANK_RESET);
        irq_is(1'b1);
        live.low_rail_comparator = 1'b1;
        wr(0, 8'h80, 8'h41, 1'b0);
        check({4'h0, wmode[0], page[0]}, 8'h09);
        check({4'h0, wmode[1], page[1]}, 8'h00);
        rd(0, 8'h80, 8'h41);
        rd(0, OFS_LIVE_A, 8'h00);
        rd(1, OFS_LIVE_A, 8'h08);
        for (int k = 0; k < 4; k++) begin
            wr(2, 8'h00, 8'(k), 1'b0);
            check({5'h00, page[2]}, 8'(k));
        end
        wr(1, 8'h00, 8'h82, 1'b1);
        check({5'h00, page[1]}, 8'h00);
        rd(1, 8'h80, 8'h80);
        wr(0, 8'h00, 8'h00, 1'b0);
        wr(2, 8'h00, 8'h00, 1'b0);
        $display("test bank_select done");
        // Events seen during power-up must not raise the request.
        pulse_evt(1);
        irq_is(1'b1);
        pwrup = 1'b0;
        irq_is(1'b1);
        clr(0, OFS_EVENT_CORE, 8'h02);
        for (int i = 0; i < 5; i++) begin
            pulse_evt(i);
            irq_is(1'b0);
            clr(i % 3, OFS_EVENT_CORE, 8'(1 << i));
            irq_is(1'b1);
        end
        mask = 5'h04;
        pulse_evt(2);
        irq_is(1'b1);
        other_irq = 1'b1;
        irq_is(1'b0);
        other_irq = 1'b0;
        mask = 5'h00;
        irq_is(1'b0);
        clr(1, OFS_EVENT_CORE, 8'h04);
        pulse_evt(1);
        rd(2, OFS_EVENT_CORE, 8'h02);
        fork
            wr(2, OFS_EVENT_CORE, 8'h02, 1'b0);
            pulse_evt(4);
        join
        rd(2, OFS_EVENT_CORE, 8'h10);
        clr(2, OFS_EVENT_CORE, 8'h10);
        for (int v = 0; v < 8; v++) begin
            other = 3'(v);
            e = {|other, other[1] | other[0], other[0], 5'h00};
            rd(0, OFS_EVENT_CORE, e);
        end
        other = '0;
        $display("test events done");
        // Before active mode an under-voltage also marks the start-up bit.
        for (int i = 0; i < 7; i++) begin
            pulse_cause(psei_cause_t'(7'(1 << i)));
            e = 8'(1 << (i < 3 ? i : i + 1)) | ((i == 2) ? 8'h08 : 8'h00);
            rd(i % 3, OFS_CAUSE_LOG, e);
            clr(i % 3, OFS_CAUSE_LOG, e);
        end
        active = 1'b1;
        pulse_cause(psei_cause_t'(7'h04));
        clr(0, OFS_CAUSE_LOG, 8'h0C);
        repeat (WIN + 5) @(posedge clk_sys_in);
        pulse_cause(psei_cause_t'(7'h0C));
        rd(1, OFS_CAUSE_LOG, 8'h14);
        wr(1, OFS_CAUSE_LOG, 8'h10, 1'b0);
        clr(1, OFS_CAUSE_LOG, 8'h04);
        $display("test shutdown_log done");
        for (int n = 0; n < 12; n++) begin
            seed = xorshift(seed);
            live = psei_live_t'(seed[30:0]);
            rd(n % 3, OFS_LIVE_A, {4'h0, live.low_rail_comparator, live.voltage_ramp_active,
                live.charger_wake_input, ~live.power_button_n});
            e = live.general_input[7:0];
            for (int b = 0; b < 3; b++) if (live.analog_mode[b]) e[b] = live.analog_input_high[b];
            rd(n % 3, OFS_LEVELS_LO, e);
            rd(n % 3, OFS_LEVELS_HI, live.general_input[15:8]);
            wr(n % 3, OFS_REG_LIMIT, 8'hFF, 1'b0);
            rd(n % 3, OFS_REG_LIMIT, {live.regulator_overcurrent, 3'h0});
        end
        $display("test live_status done");
        repeat (4) @(posedge clk_sys_in);
        test_done();
    end
endmodule // test_pmic_status_event_irq
`default_nettype wire

/* File: verilog/psei_bank_select.sv */
// Purpose: Bank-select register of one host control port.
// Assumes: Access strobes come from that port's serial front end.
// Notes: Reachable at offset 0x00 of every page.
`timescale 1ns/1ps
`default_nettype none
module psei_bank_select (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Port access.
    input wire psei_pkg::psei_access_t access_in,
    // Register value.
    output logic [7:0] bank_out
);
    import psei_pkg::*;

    typedef struct packed {
        logic [7:0] bank;
    } psei_bank_state_t;

    psei_bank_state_t q, d;
    logic sel;

    // Low seven address bits decide, so both page bases alias here.
    assign sel = access_in.valid && access_in.write && access_in.addr[6:0] == OFS_BANK;

    // Auto-return acts once the transaction ends, after any write in it.
    always_comb begin
        d = q;
        if (sel) begin
            d.bank = access_in.wdata;
        end
        if (access_in.done && d.bank[BANK_RETURN_BIT]) begin
            d.bank[2:0] = PAGE_0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= '{bank: BANK_RESET};
        end else begin
            q <= d;
        end
    end

    assign bank_out = q.bank;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    chk_return_page: assert property (access_in.done && bank_out[BANK_RETURN_BIT] && !sel
        |=> bank_out[2:0] == PAGE_0)
        else $error("page not returned after access");
endmodule // psei_bank_select
`default_nettype wire

/* File: verilog/psei_pkg.sv */
// Purpose: Shared constants and types for the power-management status and event block.
// Assumes: One 40 MHz logic clock, synchronous active-high reset.
// Notes: Offsets are within-page byte addresses seen by the serial front ends.
`default_nettype none
package psei_pkg;
    // Host control ports: the 4-wire port and the two 2-wire ports.
    localparam int NUM_PORTS = 3;
    // Register offsets inside a page.
    localparam logic [6:0] OFS_BANK = 7'h00;
    localparam logic [7:0] OFS_LIVE_A = 8'h01;
    localparam logic [7:0] OFS_LEVELS_LO = 8'h02;
    localparam logic [7:0] OFS_LEVELS_HI = 8'h03;
    localparam logic [7:0] OFS_REG_LIMIT = 8'h04;
    localparam logic [7:0] OFS_CAUSE_LOG = 8'h05;
    localparam logic [7:0] OFS_EVENT_CORE = 8'h06;
    // Bank-select layout and reset value.
    localparam int BANK_RETURN_BIT = 7;
    localparam int BANK_WMODE_BIT = 6;
    localparam logic [2:0] PAGE_0 = 3'h0;
    localparam logic [7:0] BANK_RESET = 8'h00;
    // Shutdown-cause log bit positions.
    localparam int LOG_WAIT = 7;
    localparam int LOG_PIN = 6;
    localparam int LOG_KEY = 5;
    localparam int LOG_HEAT = 4;
    localparam int LOG_START_UV = 3;
    localparam int LOG_UV = 2;
    localparam int LOG_COLD = 1;
    localparam int LOG_WDOG = 0;
    localparam int LOG_W = 8;
    // Core event register: five latched bits under three summary bits.
    localparam int EVENT_W = 5;
    localparam logic [EVENT_W-1:0] EVENT_RESET = 5'h00;
    localparam logic [LOG_W-1:0] LOG_RESET = 8'h00;
    // Start-up under-voltage window.
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned START_WINDOW_S = 16;
    localparam int unsigned START_WINDOW_CYCLES = START_WINDOW_S * CLK_HZ;
    localparam int CNT_W = 30;

    // One register access from a serial front end; done marks the end of the transaction.
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic done;
    } psei_access_t;

    // Monitored live signals.
    typedef struct packed {
        logic low_rail_comparator;
        logic voltage_ramp_active;
        logic charger_wake_input;
        logic power_button_n;
        logic [15:0] general_input;
        logic [2:0] analog_mode;
        logic [2:0] analog_input_high;
        logic [4:0] regulator_overcurrent;
    } psei_live_t;

    // Power-down and start-up causes, one-cycle pulses.
    typedef struct packed {
        logic wait_timeout;
        logic pin_forced_poweroff;
        logic long_key_press;
        logic junction_overheat;
        logic supply_undervoltage;
        logic cold_start;
        logic watchdog_violation;
    } psei_cause_t;

    // Top-level state.
    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] rdata;
        logic irq_n;
        logic irq_hold;
        logic button_prev;
        logic [CNT_W-1:0] active_cnt;
    } psei_top_state_t;
endpackage
`default_nettype wire

/* File: verilog/psei_status_event.sv */
// Purpose: Bank selects, live status view, shutdown-cause log and core event register
//          with interrupt request generation.
// Assumes: Serial front ends deliver decoded byte accesses; all inputs are synchronous.
// Notes: Read data is captured one cycle after the read request.
//
// Behaviour
// - Bank select sits at offset 0x00 of every page, so 0x00 and 0x80.
// - Each host port owns its own bank select register.
// - Page field 000/001/010 selects the three register pages; 011 is test.
// - With auto-return set, page returns to zero when the access ends.
// - Bit 6 chooses page (0) or repeated (1) multiple-write mode.
// - Status reads give the live signal values with source polarity, except the button bit, which is inverted.
// - Status 0x01 shows comparator, ramping and charger wake level.
// - Status 0x01 bit 0 is high while the power button is held low.
// - Status 0x02/0x03 show general inputs; analog inputs show high threshold.
// - Status 0x04 bits 7:3 show regulator over-current limits.
// - Log 0x05 records the power-down cause bits.
// - Log bit 3 marks under-voltage before or within 16 s of active mode.
// - Log bit 1 marks a start from no-power or delivery state.
// - An event bit sets whenever its monitored signal changes.
// - Any unmasked set event asserts the interrupt request.
// - Request stays inactive during power-up and until events are cleared.
// - Events arriving during a clear are held and posted afterwards.
// - Event 0x06 bits 7:5 summarise the second to fourth event registers.
// - Event 0x06 bits 4:0 latch sequencer, ADC, tick, alarm, button.
// - Request releases once no unmasked core event is set and no other event register requests.
// - A mask blocks the request but the event is still recorded.
`timescale 1ns/1ps
`default_nettype none
module psei_status_event #(
    parameter int unsigned START_WINDOW_CYCLES = psei_pkg::START_WINDOW_CYCLES
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Host register accesses, one per control port.
    input wire psei_pkg::psei_access_t [psei_pkg::NUM_PORTS-1:0] host_access_in,
    output logic [psei_pkg::NUM_PORTS-1:0][7:0] rdata_out,
    output logic [psei_pkg::NUM_PORTS-1:0] write_mode_out,
    output logic [psei_pkg::NUM_PORTS-1:0][2:0] page_out,
    // Monitored signals and causes.
    input wire psei_pkg::psei_live_t live_in,
    input wire psei_pkg::psei_cause_t cause_in,
    input wire logic active_mode_in,
    input wire logic powerup_seq_in,
    // Event sources of the core register.
    input wire logic sequencer_done_event_in,
    input wire logic adc_ready_event_in,
    input wire logic rtc_tick_event_in,
    input wire logic rtc_alarm_event_in,
    // Other event registers and mask.
    input wire logic [2:0] other_events_set_in,
    input wire logic other_irq_pending_in,
    input wire logic [psei_pkg::EVENT_W-1:0] event_mask_in,
    // Interrupt request.
    output logic interrupt_request_n_out
);
    import psei_pkg::*;

    psei_top_state_t q, d;
    logic [NUM_PORTS-1:0][7:0] bank;
    logic [EVENT_W-1:0] event_flags;
    logic [EVENT_W-1:0] event_set;
    logic [EVENT_W-1:0] event_clr_mask;
    logic [LOG_W-1:0] log_flags;
    logic [LOG_W-1:0] log_set;
    logic [LOG_W-1:0] log_clr_mask;
    logic event_clr;
    logic log_clr;
    logic in_start_window;
    logic pending;
    logic [7:0] summary;

    // One bank select per port, so a page change on one port leaves the others alone.
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_bank
        psei_bank_select u_bank (
            .clk_sys_in(clk_sys_in),
            .rst_in(rst_in),
            .access_in(host_access_in[p]),
            .bank_out(bank[p])
        );
        assign write_mode_out[p] = bank[p][BANK_WMODE_BIT];
        assign page_out[p] = bank[p][2:0];
    end

    // True when the access hits a page-0 register at the given offset.
    function automatic logic hit(input psei_access_t acc, input logic [7:0] pg_bank,
                                 input logic [7:0] ofs);
        hit = acc.valid && pg_bank[2:0] == PAGE_0 && acc.addr == ofs;
    endfunction

    // Summary bits cascade so software can find the lowest register needing service.
    assign summary = {|other_events_set_in, |other_events_set_in[1:0],
                      other_events_set_in[0], 5'h00};

    // Read decode; status fields come straight from the live inputs.
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input logic [7:0] pg_bank);
        logic [7:0] gi_lo;
        gi_lo = live_in.general_input[7:0];
        for (int i = 0; i < 3; i++) begin
            if (live_in.analog_mode[i]) begin
                gi_lo[i] = live_in.analog_input_high[i];
            end
        end
        read_reg = 8'h00;
        if (addr[6:0] == OFS_BANK) begin
            read_reg = pg_bank;
        end else if (pg_bank[2:0] == PAGE_0) begin
            unique case (addr)
                OFS_LIVE_A: read_reg = {4'h0, live_in.low_rail_comparator,
                    live_in.voltage_ramp_active, live_in.charger_wake_input,
                    !live_in.power_button_n};
                OFS_LEVELS_LO: read_reg = gi_lo;
                OFS_LEVELS_HI: read_reg = live_in.general_input[15:8];
                OFS_REG_LIMIT: read_reg = {live_in.regulator_overcurrent, 3'h0};
                OFS_CAUSE_LOG: read_reg = log_flags;
                OFS_EVENT_CORE: read_reg = summary | {3'h0, event_flags};
                default: read_reg = 8'h00;
            endcase
        end
    endfunction

    // Write-back clears from any port are merged; the host only writes what it read.
    always_comb begin
        event_clr = 1'b0;
        log_clr = 1'b0;
        event_clr_mask = '0;
        log_clr_mask = '0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (host_access_in[p].write && hit(host_access_in[p], bank[p], OFS_EVENT_CORE)) begin
                event_clr = 1'b1;
                event_clr_mask = event_clr_mask | host_access_in[p].wdata[EVENT_W-1:0];
            end
            if (host_access_in[p].write && hit(host_access_in[p], bank[p], OFS_CAUSE_LOG)) begin
                log_clr = 1'b1;
                log_clr_mask = log_clr_mask | host_access_in[p].wdata;
            end
        end
    end

    // Under-voltage counts as a start-up failure outside active mode or early in it.
    assign in_start_window = !active_mode_in || q.active_cnt < CNT_W'(START_WINDOW_CYCLES);

    // Log sources in bit order.
    always_comb begin
        log_set = '0;
        log_set[LOG_WAIT] = cause_in.wait_timeout;
        log_set[LOG_PIN] = cause_in.pin_forced_poweroff;
        log_set[LOG_KEY] = cause_in.long_key_press;
        log_set[LOG_HEAT] = cause_in.junction_overheat;
        log_set[LOG_START_UV] = cause_in.supply_undervoltage && in_start_window;
        log_set[LOG_UV] = cause_in.supply_undervoltage;
        log_set[LOG_COLD] = cause_in.cold_start;
        log_set[LOG_WDOG] = cause_in.watchdog_violation;
    end

    // Button events on either edge of the pin; other sources are pulses.
    assign event_set = {sequencer_done_event_in, adc_ready_event_in, rtc_tick_event_in,
                        rtc_alarm_event_in,
                        live_in.power_button_n ^ q.button_prev};

    psei_sticky_flags #(.W(LOG_W), .RESET_VAL(LOG_RESET)) u_log (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .set_in(log_set),
        .clear_in(log_clr),
        .clear_mask_in(log_clr_mask),
        .flags_out(log_flags)
    );

    psei_sticky_flags #(.W(EVENT_W), .RESET_VAL(EVENT_RESET)) u_event (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .set_in(event_set),
        .clear_in(event_clr),
        .clear_mask_in(event_clr_mask),
        .flags_out(event_flags)
    );

    // Masks gate the request only; the flags above record regardless.
    assign pending = |(event_flags & ~event_mask_in) || other_irq_pending_in;

    // Next state: read capture, start window count, request hold and output.
    always_comb begin
        d = q;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (host_access_in[p].valid && !host_access_in[p].write) begin
                d.rdata[p] = read_reg(host_access_in[p].addr, bank[p]);
            end
        end
        d.button_prev = live_in.power_button_n;
        if (!active_mode_in) begin
            d.active_cnt = '0;
        end else if (q.active_cnt < CNT_W'(START_WINDOW_CYCLES)) begin
            d.active_cnt = q.active_cnt + CNT_W'(1);
        end
        // The hold survives power-up until every event register reads clear.
        if (powerup_seq_in) begin
            d.irq_hold = 1'b1;
        end else if (event_flags == '0 && other_events_set_in == '0) begin
            d.irq_hold = 1'b0;
        end
        d.irq_n = !(pending && !d.irq_hold);
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= '{rdata: '0, irq_n: 1'b1, irq_hold: 1'b1, button_prev: 1'b1, active_cnt: '0};
        end else begin
            q <= d;
        end
    end

    assign rdata_out = q.rdata;
    assign interrupt_request_n_out = q.irq_n;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence live_a_read;
        host_access_in[0].valid && !host_access_in[0].write
            && hit(host_access_in[0], bank[0], OFS_LIVE_A);
    endsequence

    chk_bank_alias: assert property (host_access_in[0].valid && !host_access_in[0].write
        && host_access_in[0].addr == 8'h80 |=> rdata_out[0] == $past(bank[0]))
        else $error("bank select not readable at upper base");
    chk_port_isolate: assert property (!host_access_in[1].valid && !host_access_in[1].done
        |=> bank[1] == $past(bank[1]))
        else $error("bank select changed without own access");
    chk_wmode_bit: assert property (host_access_in[2].valid && host_access_in[2].write
        && host_access_in[2].addr == 8'h00 |=> write_mode_out[2] == $past(host_access_in[2].wdata[6]))
        else $error("write mode bit not taken");
    chk_live_button: assert property (live_a_read
        |=> rdata_out[0][0] == !$past(live_in.power_button_n))
        else $error("status button bit wrong polarity");
    chk_start_uv: assert property (cause_in.supply_undervoltage && !active_mode_in && !log_clr
        |=> log_flags[LOG_START_UV] && log_flags[LOG_UV])
        else $error("start-up under-voltage not logged");
    chk_button_evt: assert property ($changed(live_in.power_button_n) && !event_clr
        |=> event_flags[0])
        else $error("button change not latched");
    chk_irq_assert: assert property (pending && !powerup_seq_in && !q.irq_hold
        |=> !interrupt_request_n_out)
        else $error("request not asserted for unmasked event");
    chk_irq_powerup: assert property (powerup_seq_in
        |=> interrupt_request_n_out && q.irq_hold)
        else $error("request active during power-up");
    chk_mask_blocks: assert property (event_flags == event_mask_in && !other_irq_pending_in
        |=> interrupt_request_n_out)
        else $error("masked event drove request");
    chk_summary_bits: assert property (host_access_in[0].valid && !host_access_in[0].write
        && hit(host_access_in[0], bank[0], OFS_EVENT_CORE)
        |=> rdata_out[0][7:5] == {|$past(other_events_set_in), |$past(other_events_set_in[1:0]),
        $past(other_events_set_in[0])})
        else $error("summary bits wrong");
endmodule // psei_status_event
`default_nettype wire

/* File: verilog/psei_sticky_flags.sv */
// Purpose: Sticky flag register with write-one-to-clear and hold-off of new sets.
// Assumes: clear_in is high during the clearing write cycle.
// Notes: Sets seen while clearing are posted one cycle later, never dropped.
`timescale 1ns/1ps
`default_nettype none
module psei_sticky_flags #(
    parameter int W = 8,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // Sources and host clear.
    input wire logic [W-1:0] set_in,
    input wire logic clear_in,
    input wire logic [W-1:0] clear_mask_in,
    // Flags.
    output logic [W-1:0] flags_out
);
    import psei_pkg::*;

    typedef struct packed {
        logic [W-1:0] flags;
        logic [W-1:0] held;
    } psei_sticky_state_t;

    psei_sticky_state_t q, d;

    // A clear only touches bits written as one; new sets wait until it is over.
    always_comb begin
        d = q;
        if (clear_in) begin
            d.flags = q.flags & ~clear_mask_in;
            d.held = q.held | set_in;
        end else begin
            d.flags = q.flags | set_in | q.held;
            d.held = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q <= '{flags: RESET_VAL, held: RESET_VAL};
        end else begin
            q <= d;
        end
    end

    assign flags_out = q.flags;

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence set_during_clear;
        clear_in && (set_in != '0);
    endsequence

    chk_no_lost_set: assert property (set_during_clear ##1 !clear_in
        |=> ((flags_out & $past(set_in, 2)) == $past(set_in, 2)))
        else $error("event lost during clear");
    chk_clear_ones: assert property (clear_in |=> (flags_out & $past(q.flags)
        & ~$past(clear_mask_in)) == ($past(q.flags) & ~$past(clear_mask_in)))
        else $error("flag written as zero was cleared");
endmodule // psei_sticky_flags
`default_nettype wire
